// >>> core/i2cst_pkg.sv
/*
  shared constants of the i2c status and scl timing block: register offsets,
  field positions, reset values, special addresses and counter width.
  assumes a 32-bit axi4-lite register bus with byte addressing.
*/
package i2cst_pkg;
  localparam int AXI_AW = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_OWN_ADDR = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFF_BUS_STATUS_SECOND = 8'h18;
  localparam logic [7:0] OFF_MASTER_SCL_TIMING = 8'h1C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // control register bits
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_PEC_BIT = 1;
  localparam int CTRL_ARP_BIT = 2;
  localparam int CTRL_HTS_BIT = 3;
  // own address register fields
  localparam int OA1_LSB = 0;
  localparam int OA2_LSB = 8;
  // bus_status_second fields
  localparam int ST_MASTER_BIT = 0;
  localparam int ST_BUSY_BIT = 1;
  localparam int ST_DIR_BIT = 2;
  localparam int ST_GC_BIT = 4;
  localparam int ST_DFLT_BIT = 5;
  localparam int ST_HDR_BIT = 6;
  localparam int ST_DUAL_BIT = 7;
  localparam int ST_PEC_LSB = 8;
  // master_scl_timing fields
  localparam int TM_DIV_LSB = 0;
  localparam int TM_DIV_W = 12;
  localparam int TM_DUTY_BIT = 14;
  localparam int TM_SPEED_BIT = 15;
  localparam logic [15:0] TM_RESET = 16'h0000;
  // interrupt status bits
  localparam int IRQ_W = 3;
  localparam int IRQ_STOP_BIT = 0;
  localparam int IRQ_MATCH_BIT = 1;
  localparam int IRQ_ARB_BIT = 2;
  // special seven-bit addresses
  localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
  localparam logic [6:0] SMBUS_DEFAULT_ADDR = 7'h61;
  localparam logic [6:0] SMBUS_HOST_HEADER_ADDR = 7'h08;
  // scl counter width and phase multipliers
  localparam int SCL_CNT_W = 16;
  localparam logic [15:0] FAST_D1_HIGH_MUL = 16'h0009;
  localparam logic [15:0] FAST_D1_LOW_MUL = 16'h0010;
  localparam logic [15:0] FAST_D0_LOW_MUL = 16'h0002;
endpackage

// >>> core/i2cst_scl_gen.sv
/*
  master scl phase generator: counts high and low phases in peripheral clock
  cycles from the divider, speed and duty settings.
  assumes run comes from same-clock logic; releases scl while not running.
*/
`timescale 1ns/10ps
module i2cst_scl_gen (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [i2cst_pkg::TM_DIV_W-1:0] scl_divider,
  input wire logic speed_select,
  input wire logic fast_duty_select,
  output logic scl_oe
);
  typedef struct packed {
    logic low;
    logic [i2cst_pkg::SCL_CNT_W-1:0] cnt;
  } i2cst_gen_s;

  i2cst_gen_s r;
  i2cst_gen_s n;
  logic [i2cst_pkg::SCL_CNT_W-1:0] div_w;
  logic [i2cst_pkg::SCL_CNT_W-1:0] high_len;
  logic [i2cst_pkg::SCL_CNT_W-1:0] low_len;
  logic [i2cst_pkg::SCL_CNT_W-1:0] cur_len;

  assign div_w = {{(i2cst_pkg::SCL_CNT_W - i2cst_pkg::TM_DIV_W){1'b0}}, scl_divider};

  always_comb begin
    high_len = div_w;
    low_len = div_w;
    if (speed_select) begin
      if (fast_duty_select) begin
        high_len = div_w * i2cst_pkg::FAST_D1_HIGH_MUL;
        low_len = div_w * i2cst_pkg::FAST_D1_LOW_MUL;
      end else begin
        low_len = div_w * i2cst_pkg::FAST_D0_LOW_MUL;
      end
    end
    cur_len = r.low ? low_len : high_len;
  end

  always_comb begin
    n = r;
    // divider zero would wrap the length compare into 65536-cycle phases; keep scl released
    if (!run || scl_divider == '0) begin
      n.low = 1'b0;
      n.cnt = '0;
    end else if (r.cnt >= cur_len - 1'b1) begin
      n.low = ~r.low;
      n.cnt = '0;
    end else begin
      n.cnt = r.cnt + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign scl_oe = r.low;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  phase_end_a: assert property (
    run && scl_divider != '0 && $stable(scl_divider) && r.cnt == cur_len - 1'b1
      |=> r.low != $past(r.low) && r.cnt == '0)
    else $error("scl phase did not end at its length");
endmodule

// >>> core/i2cst_top.sv
/*
  i2c status and master scl timing block: second status register, scl
  timing register, own control, own addresses, interrupt status and mask,
  all over an axi4-lite slave; drives scl low through an open-drain enable.
  assumes the byte engine of the controller sits on the same clock and
  pulses master_start, stop_gen, arb_lost and addr_done; sda and scl pins
  are asynchronous and are synchronised here.
*/
// The AXI4-Lite register port was chosen for this implementation.
// Overview of operation
// - bit 0 of the second status reads 1 as bus master and 0 as slave.
// - the master flag clears on a generated stop, lost arbitration or disable.
// - bus busy sets while sda or scl is low and clears after a stop on the bus.
// - bit 2 follows the address read/write bit, 1 meaning this end transmits.
// - the direction flag clears on stop, repeated start, lost arbitration or disable.
// - bit 4 sets in slave mode on the general call address, cleared on stop, restart or disable.
// - bit 5 sets in slave mode with address resolution on the smbus default address, same clears.
// - bit 6 sets in slave mode on the smbus host header with host type and resolution on.
// - bit 7 reads 0 for a first own address match and 1 for a second, same clears.
// - with packet checking on, bits 15:8 show the computed check value.
// - in standard mode scl high and low each last divider clock periods.
// - in fast mode with duty 0, high is divider periods and low twice that.
// - in fast mode with duty 1, high is 9 and low 16 times the divider periods.
// - timing bit 15 picks fast over standard, bit 14 picks the fast duty.
`timescale 1ns/10ps
module i2cst_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [i2cst_pkg::AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [i2cst_pkg::AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic sda_i,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic master_start,
  input wire logic stop_gen,
  input wire logic arb_lost,
  input wire logic addr_done,
  input wire logic [7:0] addr_byte,
  input wire logic [7:0] pec_value,
  output logic irq
);
  typedef struct packed {
    logic sda_s1;
    logic sda_s2;
    logic sda_s3;
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic en;
    logic pec_en;
    logic arp_en;
    logic hts;
    logic [6:0] oa1;
    logic [6:0] oa2;
    logic [15:0] timing;
    logic master;
    logic busy;
    logic dir;
    logic gc;
    logic dflt;
    logic hdr;
    logic dual;
    logic [7:0] pec;
    logic [i2cst_pkg::IRQ_W-1:0] ist;
    logic [i2cst_pkg::IRQ_W-1:0] imask;
    logic irq;
  } i2cst_top_s;

  i2cst_top_s r;
  i2cst_top_s n;
  logic start_seen;
  logic stop_seen;
  logic stop_any;
  logic rstart;
  logic slv_addr;
  logic [6:0] a7;
  logic rw;
  logic flag_clr;
  logic dir_clr;
  logic wr_hs;
  logic rd_hs;
  logic [15:0] status2;
  logic [i2cst_pkg::IRQ_W-1:0] ist_set;
  logic match_any;

  // only the synchronised copies feed the detectors
  assign start_seen = r.scl_s2 & r.scl_s3 & r.sda_s3 & ~r.sda_s2;
  assign stop_seen = r.scl_s2 & r.scl_s3 & ~r.sda_s3 & r.sda_s2;
  assign stop_any = stop_seen | stop_gen;
  assign rstart = start_seen & r.busy;
  assign a7 = addr_byte[7:1];
  assign rw = addr_byte[0];
  assign slv_addr = addr_done & ~r.master & r.en;
  assign flag_clr = stop_any | rstart | ~r.en;
  assign dir_clr = flag_clr | arb_lost;
  assign wr_hs = awvalid & r.awready & wvalid & r.wready;
  assign rd_hs = arvalid & r.arready;
  // own-address part only; the special-address part comes from the flag updates
  assign match_any = (a7 == r.oa1) | (a7 == r.oa2);

  always_comb begin
    status2 = '0;
    status2[i2cst_pkg::ST_MASTER_BIT] = r.master;
    status2[i2cst_pkg::ST_BUSY_BIT] = r.busy;
    status2[i2cst_pkg::ST_DIR_BIT] = r.dir;
    status2[i2cst_pkg::ST_GC_BIT] = r.gc;
    status2[i2cst_pkg::ST_DFLT_BIT] = r.dflt;
    status2[i2cst_pkg::ST_HDR_BIT] = r.hdr;
    status2[i2cst_pkg::ST_DUAL_BIT] = r.dual;
    status2[i2cst_pkg::ST_PEC_LSB +: 8] = r.pec;
  end

  always_comb begin
    n = r;
    ist_set = '0;
    n.sda_s1 = sda_i;
    n.sda_s2 = r.sda_s1;
    n.sda_s3 = r.sda_s2;
    n.scl_s1 = scl_i;
    n.scl_s2 = r.scl_s1;
    n.scl_s3 = r.scl_s2;

    // role: clears take priority, the engine never pulses both at once
    if (!r.en || stop_gen || arb_lost) begin
      n.master = 1'b0;
    end else if (master_start) begin
      n.master = 1'b1;
    end

    n.busy = ~r.sda_s2 | ~r.scl_s2 | (r.busy & ~stop_seen);

    if (dir_clr) begin
      n.dir = 1'b0;
    end else if (addr_done && r.en) begin
      // a master reading receives, a slave being read transmits
      n.dir = r.master ? ~rw : rw;
    end

    if (flag_clr) begin
      n.gc = 1'b0;
      n.dflt = 1'b0;
      n.hdr = 1'b0;
      n.dual = 1'b0;
    end else if (slv_addr) begin
      n.gc = (a7 == i2cst_pkg::GENERAL_CALL_ADDR) & ~rw;
      n.dflt = r.arp_en & (a7 == i2cst_pkg::SMBUS_DEFAULT_ADDR);
      n.hdr = r.arp_en & r.hts & (a7 == i2cst_pkg::SMBUS_HOST_HEADER_ADDR);
      n.dual = (a7 == r.oa2) & (a7 != r.oa1);
    end

    n.pec = r.pec_en ? pec_value : 8'h00;

    ist_set[i2cst_pkg::IRQ_STOP_BIT] = stop_seen;
    ist_set[i2cst_pkg::IRQ_MATCH_BIT] = slv_addr & ~flag_clr & (match_any | n.gc | n.dflt | n.hdr);
    ist_set[i2cst_pkg::IRQ_ARB_BIT] = arb_lost & r.master;

    // write channel: ready pulses one cycle while both valids are held
    n.awready = 1'b0;
    n.wready = 1'b0;
    if (!r.awready && !r.bvalid && awvalid && wvalid) begin
      n.awready = 1'b1;
      n.wready = 1'b1;
    end
    if (r.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    n.ist = r.ist;
    if (wr_hs) begin
      n.bvalid = 1'b1;
      n.bresp = i2cst_pkg::RESP_OKAY;
      case (awaddr)
        i2cst_pkg::OFF_CTRL: begin
          if (wstrb[0]) begin
            n.en = wdata[i2cst_pkg::CTRL_EN_BIT];
            n.pec_en = wdata[i2cst_pkg::CTRL_PEC_BIT];
            n.arp_en = wdata[i2cst_pkg::CTRL_ARP_BIT];
            n.hts = wdata[i2cst_pkg::CTRL_HTS_BIT];
          end
        end
        i2cst_pkg::OFF_OWN_ADDR: begin
          if (wstrb[0]) begin
            n.oa1 = wdata[i2cst_pkg::OA1_LSB +: 7];
          end
          if (wstrb[1]) begin
            n.oa2 = wdata[i2cst_pkg::OA2_LSB +: 7];
          end
        end
        i2cst_pkg::OFF_IRQ_STAT: begin
          if (wstrb[0]) begin
            n.ist = r.ist & ~wdata[i2cst_pkg::IRQ_W-1:0];
          end
        end
        i2cst_pkg::OFF_IRQ_MASK: begin
          if (wstrb[0]) begin
            n.imask = wdata[i2cst_pkg::IRQ_W-1:0];
          end
        end
        i2cst_pkg::OFF_BUS_STATUS_SECOND: begin
          n.bresp = i2cst_pkg::RESP_OKAY;
        end
        i2cst_pkg::OFF_MASTER_SCL_TIMING: begin
          if (wstrb[0]) begin
            n.timing[7:0] = wdata[7:0];
          end
          if (wstrb[1]) begin
            n.timing[15:8] = wdata[15:8];
          end
          n.timing[13:12] = 2'h0;
        end
        default: begin
          n.bresp = i2cst_pkg::RESP_SLVERR;
        end
      endcase
    end
    // a new event beats a simultaneous write-one clear
    n.ist = n.ist | ist_set;
    n.irq = |(n.ist & n.imask);

    n.arready = 1'b0;
    if (!r.arready && !r.rvalid && arvalid) begin
      n.arready = 1'b1;
    end
    if (r.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    if (rd_hs) begin
      n.rvalid = 1'b1;
      n.rresp = i2cst_pkg::RESP_OKAY;
      n.rdata = 32'h0000_0000;
      case (araddr)
        i2cst_pkg::OFF_CTRL: begin
          n.rdata[i2cst_pkg::CTRL_EN_BIT] = r.en;
          n.rdata[i2cst_pkg::CTRL_PEC_BIT] = r.pec_en;
          n.rdata[i2cst_pkg::CTRL_ARP_BIT] = r.arp_en;
          n.rdata[i2cst_pkg::CTRL_HTS_BIT] = r.hts;
        end
        i2cst_pkg::OFF_OWN_ADDR: begin
          n.rdata[i2cst_pkg::OA1_LSB +: 7] = r.oa1;
          n.rdata[i2cst_pkg::OA2_LSB +: 7] = r.oa2;
        end
        i2cst_pkg::OFF_IRQ_STAT: begin
          n.rdata[i2cst_pkg::IRQ_W-1:0] = r.ist;
        end
        i2cst_pkg::OFF_IRQ_MASK: begin
          n.rdata[i2cst_pkg::IRQ_W-1:0] = r.imask;
        end
        i2cst_pkg::OFF_BUS_STATUS_SECOND: begin
          n.rdata[15:0] = status2;
        end
        i2cst_pkg::OFF_MASTER_SCL_TIMING: begin
          n.rdata[15:0] = r.timing;
        end
        default: begin
          n.rresp = i2cst_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.sda_s1 <= 1'b1;
      r.sda_s2 <= 1'b1;
      r.sda_s3 <= 1'b1;
      r.scl_s1 <= 1'b1;
      r.scl_s2 <= 1'b1;
      r.scl_s3 <= 1'b1;
      r.timing <= i2cst_pkg::TM_RESET;
    end else begin
      r <= n;
    end
  end

  i2cst_scl_gen u_scl_gen (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(r.master & r.en),
    .scl_divider(r.timing[i2cst_pkg::TM_DIV_LSB +: i2cst_pkg::TM_DIV_W]),
    .speed_select(r.timing[i2cst_pkg::TM_SPEED_BIT]),
    .fast_duty_select(r.timing[i2cst_pkg::TM_DUTY_BIT]),
    .scl_oe(scl_oe)
  );

  // open drain: the pin is only ever pulled low
  assign scl_o = 1'b0;
  assign awready = r.awready;
  assign wready = r.wready;
  assign bresp = r.bresp;
  assign bvalid = r.bvalid;
  assign arready = r.arready;
  assign rdata = r.rdata;
  assign rresp = r.rresp;
  assign rvalid = r.rvalid;
  assign irq = r.irq;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  role_set_a: assert property (
    r.en && master_start && !stop_gen && !arb_lost |=> r.master ##0 status2[0])
    else $error("master flag not set after master start");
  role_clear_a: assert property (
    (!r.en || stop_gen || arb_lost) |=> !r.master)
    else $error("master flag not cleared");
  busy_set_a: assert property (
    !r.sda_s2 |=> r.busy)
    else $error("bus busy not set while a line is low");
  busy_clear_a: assert property (
    stop_seen |=> !r.busy)
    else $error("bus busy not cleared after stop");
  dir_follow_a: assert property (
    addr_done && r.en && !dir_clr |=> r.dir == ($past(r.master) ? ~$past(rw) : $past(rw)))
    else $error("direction flag does not follow read/write bit");
  dir_clear_a: assert property (
    dir_clr |=> !r.dir)
    else $error("direction flag not cleared");
  call_match_a: assert property (
    slv_addr && !flag_clr && a7 == 7'h00 && !rw |=> r.gc ##1 (r.gc || $past(flag_clr)))
    else $error("general call flag wrong");
  default_match_a: assert property (
    slv_addr && !flag_clr |=> r.dflt == ($past(r.arp_en) && $past(a7) == 7'h61))
    else $error("smbus default flag wrong");
  header_match_a: assert property (
    slv_addr && !flag_clr && a7 == 7'h08 && r.arp_en && r.hts |=> r.hdr)
    else $error("smbus host header flag not set");
  dual_match_a: assert property (
    slv_addr && !flag_clr && a7 == r.oa2 && a7 != r.oa1 |=> r.dual && status2[7])
    else $error("second own address flag not set");
  slave_clear_a: assert property (
    flag_clr |=> !(r.gc || r.dflt || r.hdr || r.dual))
    else $error("slave match flags not cleared");
  pec_show_a: assert property (
    r.pec_en |=> status2[15:8] == $past(pec_value))
    else $error("check value not shown");
  status_ro_a: assert property (
    wr_hs && awaddr == 8'h18 |=> bresp == 2'h0 && r.en == $past(r.en) && r.timing == $past(r.timing))
    else $error("status write had an effect");
endmodule

// >>> bench/i2cst_bus_model.sv
/*
  model of the other devices on the i2c wires: pulls sda and scl low
  through open drain, makes start, repeated start and stop conditions.
  assumes pull-ups on both wires and the dut scl_oe pulling scl low.
*/
`timescale 1ns/10ps
module i2cst_bus_model (
  input wire logic aclk,
  input wire logic scl_oe,
  output logic sda,
  output logic scl
);
  logic sda_pull = 1'b0;
  logic scl_pull = 1'b0;
  // wired-and with pull-ups: released lines read high
  assign sda = !sda_pull;
  assign scl = !(scl_pull || scl_oe);
  task automatic step(input logic sd, input logic sc);
    @(posedge aclk);
    sda_pull <= sd;
    scl_pull <= sc;
    // long enough for the pin synchronisers
    repeat (6) @(posedge aclk);
  endtask
  task automatic start();
    step(1'b1, 1'b0);
  endtask
  task automatic rstart();
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
  endtask
  task automatic stop();
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
endmodule

// >>> bench/tb.sv
/*
  self-checking bench of the i2c status and scl timing block.
  assumes the dut answers axi4-lite with one-cycle ready pulses and held responses.
*/
`timescale 1ns/10ps
module tb;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, master_start = 1'b0, stop_gen = 1'b0;
  logic arb_lost = 1'b0, addr_done = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, addr_byte = 8'h00, pec_value = 8'hA5;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, rs;
  logic sda_i, scl_i, scl_o, scl_oe, irq, awready, wready, bvalid, arready, rvalid;
  int err_count = 0, checks = 0, hi, lo, n, i;
  logic [7:0] sa [5] = '{8'h00, 8'hC3, 8'h10, 8'h21, 8'h44};
  logic [7:0] se [5] = '{8'h12, 8'h26, 8'h42, 8'h06, 8'h82};
  logic [31:0] tv [3] = '{32'hC001, 32'h8002, 32'h0003};
  int th [3] = '{9, 2, 3};
  int tl [3] = '{16, 4, 3};
  always #50 aclk = ~aclk;
  i2cst_top u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .sda_i(sda_i), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
    .master_start(master_start), .stop_gen(stop_gen), .arb_lost(arb_lost),
    .addr_done(addr_done), .addr_byte(addr_byte), .pec_value(pec_value), .irq(irq));
  i2cst_bus_model u_bus (.aclk(aclk), .scl_oe(scl_oe), .sda(sda_i), .scl(scl_i));
  task automatic stop_test();
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  task automatic tmo();
    err_count++;
    stop_test();
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (awready === 1'b1) begin
        awvalid <= 1'b0;
        wvalid <= 1'b0;
      end
      if (bvalid === 1'b1) break;
    end
    if (k == 50) tmo();
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (k == 50) tmo();
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    axr(a);
    chk(nm, e, rd);
    chk("read resp", 32'(i2cst_pkg::RESP_OKAY), 32'(rs));
  endtask
  task automatic eng(input int k, input logic [7:0] ab);
    @(posedge aclk);
    addr_byte <= ab;
    case (k)
      0: master_start <= 1'b1;
      1: stop_gen <= 1'b1;
      2: arb_lost <= 1'b1;
      default: addr_done <= 1'b1;
    endcase
    @(posedge aclk);
    master_start <= 1'b0;
    stop_gen <= 1'b0;
    arb_lost <= 1'b0;
    addr_done <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
  task automatic wait_oe(input logic v, output int c);
    for (c = 1; c < 300; c++) begin
      @(posedge aclk);
      if (scl_oe === v) return;
    end
    tmo();
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(8'h18, 32'h0, "status reset");
    rdc(8'h1C, 32'h0, "timing reset");
    axw(8'h1C, 32'hFFFF);
    rdc(8'h1C, 32'hCFFF, "timing rw");
    wstrb <= 4'h1;
    axw(8'h1C, 32'h0000_0011);
    wstrb <= 4'hF;
    rdc(8'h1C, 32'hCF11, "timing lane0");
    axr(8'h40);
    chk("unmapped resp", 32'(i2cst_pkg::RESP_SLVERR), 32'(rs));
    axw(8'h40, 32'h1);
    chk("unmapped wr resp", 32'(i2cst_pkg::RESP_SLVERR), 32'(rs));
    axw(8'h18, 32'hFFFF);
    chk("status wr resp", 32'(i2cst_pkg::RESP_OKAY), 32'(rs));
    rdc(8'h18, 32'h0, "status write");
    axw(8'h1C, 32'h0);
    axw(8'h04, 32'h2210);
    axw(8'h00, 32'hF);
    rdc(8'h18, 32'hA500, "pec value");
    pec_value <= 8'h3C;
    rdc(8'h18, 32'h3C00, "pec follows");
    pec_value <= 8'hA5;
    // each entry also proves the restart and stop clears
    for (i = 0; i < 5; i++) begin
      u_bus.start();
      eng(3, sa[i]);
      rdc(8'h18, {16'h0, 8'hA5, se[i]}, "slave match");
      u_bus.rstart();
      rdc(8'h18, 32'hA502, "after restart");
      u_bus.stop();
      rdc(8'h18, 32'hA500, "after stop");
    end
    eng(0, 8'h00);
    eng(3, 8'h20);
    rdc(8'h18, 32'hA505, "master write");
    eng(1, 8'h00);
    rdc(8'h18, 32'hA500, "master stop");
    eng(0, 8'h00);
    eng(3, 8'h21);
    rdc(8'h18, 32'hA501, "master read");
    eng(2, 8'h00);
    rdc(8'h18, 32'hA500, "arb lost");
    eng(0, 8'h00);
    eng(3, 8'h20);
    axw(8'h00, 32'h0);
    rdc(8'h18, 32'h0, "disable");
    axw(8'h00, 32'hF);
    eng(0, 8'h00);
    for (i = 0; i < 3; i++) begin
      axw(8'h1C, tv[i]);
      repeat (2) begin
        wait_oe(1'b0, n);
        wait_oe(1'b1, n);
      end
      wait_oe(1'b0, lo);
      wait_oe(1'b1, hi);
      chk("scl high", 32'(th[i]), 32'(hi));
      chk("scl low", 32'(tl[i]), 32'(lo));
    end
    rdc(8'h18, 32'hA503, "busy from scl");
    eng(1, 8'h00);
    repeat (40) @(posedge aclk);
    rdc(8'h18, 32'hA502, "busy held");
    u_bus.start();
    u_bus.stop();
    rdc(8'h18, 32'hA500, "busy cleared");
    chk("irq masked", 32'h0, 32'(irq));
    axw(8'h0C, 32'h7);
    rdc(8'h08, 32'h7, "irq status");
    chk("irq raised", 32'h1, 32'(irq));
    axw(8'h08, 32'h7);
    rdc(8'h08, 32'h0, "irq cleared");
    chk("irq low", 32'h0, 32'(irq));
    chk("scl drive level", 32'h0, 32'(scl_o));
    stop_test();
  end
endmodule
